// ===== logic/cfc_pkg.sv
// shared constants and types of the chopper and fault control block
package cfc_pkg;
	// timing: blanking interval, about 1 us, as least on time
	localparam int CORE_CLK_MHZ = 100;
	localparam int BLANK_NS = 1000;
	localparam int BLANK_CYCLES = (BLANK_NS * CORE_CLK_MHZ + 999) / 1000;
	localparam int BLANK_W = 8;
	// synchroniser depth
	localparam int SYNC_STAGES = 2;

	// three-level pin code
	typedef enum logic [1:0] {
		CFC_LVL_LOW = 2'b00,
		CFC_LVL_HIGH = 2'b01,
		CFC_LVL_FLOAT = 2'b10
	} cfc_tri_t;

	// bridge low-side/high-side drive of one winding
	typedef struct packed {
		logic hiA;
		logic loA;
		logic hiB;
		logic loB;
	} cfc_bridge_t;

	localparam cfc_bridge_t BRIDGE_OFF = 4'h0;

	// decoded configuration carried to the host-facing logic
	typedef struct packed {
		cfc_tri_t microstepSelectLo;
		logic [1:0] microstepSelectHi;
		cfc_tri_t stallModeSelect;
		cfc_tri_t enableSel;
	} cfc_cfg_t;

	// chopper phase states
	typedef enum logic [1:0] {
		CFC_IDLE = 2'b00,
		CFC_DRIVE = 2'b01,
		CFC_DECAY = 2'b10
	} cfc_state_t;
endpackage

// ===== logic/cfc_chopper.sv
// one winding chopper: drive until trip, slow decay until valley
`timescale 1ns/10ps
module cfc_chopper
	import cfc_pkg::*;
#(
	parameter int BLANK_COUNT = BLANK_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// control
	input wire logic runEn,
	input wire logic polarity,
	// synchronised comparators
	input wire logic tripHit,
	input wire logic valleyHit,
	// bridge drive
	output cfc_bridge_t bridge,
	output logic decayActive
);
	cfc_state_t state_q;
	logic [BLANK_W-1:0] blankCnt_q;
	logic blanked;

	assign blanked = (blankCnt_q != '0);

	// blank counter restarts at each drive start
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			blankCnt_q <= '0;
		end else if (!runEn) begin
			blankCnt_q <= '0;
		end else if (state_q != CFC_DRIVE) begin
			blankCnt_q <= BLANK_W'(BLANK_COUNT);
		end else if (blanked) begin
			blankCnt_q <= blankCnt_q - 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= CFC_IDLE;
		end else if (!runEn) begin
			state_q <= CFC_IDLE;
		end else begin
			unique case (state_q)
				CFC_IDLE: begin
					state_q <= CFC_DRIVE;
				end
				CFC_DRIVE: begin
					// comparator ignored while blanked, so drive lasts at least the blank
					if (!blanked && tripHit) begin
						state_q <= CFC_DECAY;
					end
				end
				CFC_DECAY: begin
					// no fixed off time: only the valley ends decay
					if (valleyHit) begin
						state_q <= CFC_DRIVE;
					end
				end
				default: begin
					state_q <= CFC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bridge <= BRIDGE_OFF;
			decayActive <= 1'b0;
		end else begin
			decayActive <= 1'b0;
			bridge <= BRIDGE_OFF;
			if (runEn && state_q == CFC_DECAY) begin
				// slow decay only: both low sides on, never reversed drive
				bridge <= '{hiA: 1'b0, loA: 1'b1, hiB: 1'b0, loB: 1'b1};
				decayActive <= 1'b1;
			end else if (runEn && state_q != CFC_IDLE) begin
				bridge <= polarity ? cfc_bridge_t'{hiA: 1'b1, loA: 1'b0, hiB: 1'b0, loB: 1'b1}
					: cfc_bridge_t'{hiA: 1'b0, loA: 1'b1, hiB: 1'b1, loB: 1'b0};
			end
		end
	end
endmodule

// ===== logic/cfc_top.sv
// bridge chopping, lockouts, fault and stall report pins
`timescale 1ns/10ps
// How it works
// - slow decay is the only decay mode
// - at threshold, both low sides recirculate current
// - decay from trip level until valley level
// - no fixed off time; valley ends decay
// - comparator ignored for about 1 us blanking
// - blanking is the minimum drive time
// - fault pin pulled low on any fault
// - fault pin released after clean power-up
// - stall report released when stall detected
// - stall report pulled low after learning success
// - stall report held low externally suppresses stall faults
// - supply lockout: bridges off, fault, pump off
// - supply lockout clear: resume, release fault automatically
// - pump lockout: bridges off, fault, pump on
// - pump lockout clear: resume, release fault automatically
// - logic supply off in sleep or no supply
// - lower microstep, stall mode, enable are three-level
// - upper microstep select is four-level
// - step, direction, sleep request are two-level
module cfc_top
	import cfc_pkg::*;
#(
	parameter int BLANK_COUNT = cfc_pkg::BLANK_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// supply monitors, asynchronous
	input wire logic supplyLowLockout,
	input wire logic pumpLowLockout,
	input wire logic motorSupplyOk,
	// winding current comparators, asynchronous
	input wire logic [1:0] tripLevel,
	input wire logic [1:0] valleyLevel,
	// winding polarity from indexer, same domain
	input wire logic [1:0] windingPolarity,
	// other fault sources, same domain
	input wire logic otherFault,
	input wire logic stallDetected,
	input wire logic learnDone,
	// logic pins, asynchronous
	input wire logic stepIn,
	input wire logic dirIn,
	input wire logic lowPowerRequest,
	// multi-level pins: pull-up and pull-down probe comparators
	input wire logic [1:0] microstepSelectLoRaw,
	input wire logic [1:0] stallModeSelectRaw,
	input wire logic [1:0] enableRaw,
	input wire logic [1:0] microstepSelectHiRaw,
	// open-drain pins
	input wire logic stallReportIn,
	output logic faultFlagLowOut,
	output logic faultFlagLowOe,
	output logic stallReportOut,
	output logic stallReportOe,
	// bridge, pump and regulator
	output cfc_bridge_t bridgeA,
	output cfc_bridge_t bridgeB,
	output logic pumpEnable,
	output logic logicSupplyOut,
	// decoded inputs
	output cfc_cfg_t cfgOut,
	output logic stepOut,
	output logic dirOut,
	output logic stallReportSuppressed
);
	localparam int NSYNC = 19;
	logic [NSYNC-1:0] syncRaw;
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] sync2_q;
	logic uvS, cpS, vmS, sleepReqS, stallPinS, stepS, dirS;
	logic [1:0] tripS, valleyS;
	logic [1:0] m0S, smS, enS, m1S;
	logic bridgeRun;
	logic anyFault;
	logic stallFault;
	logic learnMode;
	cfc_bridge_t [1:0] bridgeD;
	logic [1:0] stallOeDly_q;

	// three-level decode from a high and low probe pair
	function automatic cfc_tri_t decodeTri(input logic [1:0] p);
		if (p == 2'b11) begin
			decodeTri = CFC_LVL_HIGH;
		end else if (p == 2'b00) begin
			decodeTri = CFC_LVL_LOW;
		end else begin
			decodeTri = CFC_LVL_FLOAT;
		end
	endfunction

	assign syncRaw = {supplyLowLockout, pumpLowLockout, motorSupplyOk, tripLevel, valleyLevel,
		stepIn, dirIn, lowPowerRequest, microstepSelectLoRaw, stallModeSelectRaw, enableRaw,
		microstepSelectHiRaw, stallReportIn};

	// two flops for every pin input; only stage two is read
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= syncRaw;
			sync2_q <= sync1_q;
		end
	end

	assign {uvS, cpS, vmS, tripS, valleyS, stepS, dirS, sleepReqS, m0S, smS, enS, m1S, stallPinS} = sync2_q;

	// bridge runs only with no lockout and awake
	assign bridgeRun = !uvS && !cpS && vmS && sleepReqS && !otherFault;

	genvar w;
	generate
		for (w = 0; w < 2; w++) begin : gWinding
			cfc_chopper #(
				.BLANK_COUNT(BLANK_COUNT)
			) uChop (
				.core_clk(core_clk),
				.rst_n(rst_n),
				.runEn(bridgeRun),
				.polarity(windingPolarity[w]),
				.tripHit(tripS[w]),
				.valleyHit(valleyS[w]),
				.bridge(bridgeD[w]),
				.decayActive()
			);
		end
	endgenerate

	// learning mode is stall mode floating
	assign learnMode = (decodeTri(smS) == CFC_LVL_FLOAT);
	// stall fault only counts outside learning and when not suppressed
	assign stallFault = stallDetected && !learnMode && stallPinS;
	// fault is a plain level of live sources, so it self-clears
	assign anyFault = uvS || cpS || otherFault || stallFault;

	// fault pin: oe low drives low; released at reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			faultFlagLowOut <= 1'b0;
			faultFlagLowOe <= 1'b1;
		end else begin
			faultFlagLowOut <= 1'b0;
			faultFlagLowOe <= !anyFault;
		end
	end

	// stall report: pulled low normally or after learning, released on stall
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stallReportOut <= 1'b0;
			stallReportOe <= 1'b1;
		end else begin
			stallReportOut <= 1'b0;
			if (learnMode) begin
				stallReportOe <= !learnDone;
			end else begin
				stallReportOe <= stallDetected;
			end
		end
	end

	// release state delayed to line up with the synchronised pin sense
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stallOeDly_q <= 2'b00;
		end else begin
			stallOeDly_q <= {stallOeDly_q[0], stallReportOe};
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stallReportSuppressed <= 1'b0;
		end else begin
			// pin low while we release it means someone outside holds it
			stallReportSuppressed <= !stallPinS && stallOeDly_q[1] && !learnMode;
		end
	end

	// pump off in supply lockout, asleep or unpowered; regulator off asleep or unpowered
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pumpEnable <= 1'b0;
			logicSupplyOut <= 1'b0;
		end else begin
			pumpEnable <= !uvS && vmS && sleepReqS;
			logicSupplyOut <= vmS && sleepReqS;
		end
	end

	// bridges forced off in lockout, one cycle shorter path than chopper stop
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bridgeA <= BRIDGE_OFF;
			bridgeB <= BRIDGE_OFF;
		end else begin
			bridgeA <= bridgeRun ? bridgeD[0] : BRIDGE_OFF;
			bridgeB <= bridgeRun ? bridgeD[1] : BRIDGE_OFF;
		end
	end

	// input decode
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfgOut <= '{CFC_LVL_LOW, 2'b00, CFC_LVL_LOW, CFC_LVL_LOW};
			stepOut <= 1'b0;
			dirOut <= 1'b0;
		end else begin
			cfgOut.microstepSelectLo <= decodeTri(m0S);
			cfgOut.stallModeSelect <= decodeTri(smS);
			cfgOut.enableSel <= decodeTri(enS);
			cfgOut.microstepSelectHi <= m1S;
			stepOut <= stepS;
			dirOut <= dirS;
		end
	end
endmodule

// ===== bench/cfc_winding_model.sv
// winding current model: rises while driven, falls otherwise
`timescale 1ns/10ps
module cfc_winding_model #(
	parameter int TRIP = 24,
	parameter int VALLEY = 8
) (
	input wire logic core_clk,
	input wire cfc_pkg::cfc_bridge_t bridgeA,
	input wire cfc_pkg::cfc_bridge_t bridgeB,
	output logic [1:0] tripLevel = 2'h0,
	output logic [1:0] valleyLevel = 2'h3
);
	int cur[2] = '{0, 0};
	logic [1:0] drv;
	// comparators move just after the edge, like analog levels
	always @(posedge core_clk) begin
		drv = {bridgeB.hiA ^ bridgeB.hiB, bridgeA.hiA ^ bridgeA.hiB};
		#1;
		for (int i = 0; i < 2; i++) begin
			cur[i] = drv[i] ? cur[i] + 1 : (cur[i] > 0 ? cur[i] - 1 : 0);
			tripLevel[i] = cur[i] >= TRIP;
			valleyLevel[i] = cur[i] <= VALLEY;
		end
	end
endmodule

// ===== bench/cfc_chk.sv
// concurrent checks on chopping and fault pins
`timescale 1ns/10ps
module cfc_chk
	import cfc_pkg::*;
#(
	parameter int BLANK_COUNT = BLANK_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// watched ports
	input wire logic supplyLowLockout,
	input wire logic pumpLowLockout,
	input wire logic otherFault,
	input wire logic stallDetected,
	input wire logic [1:0] tripLevel,
	input wire logic [1:0] valleyLevel,
	input wire logic faultFlagLowOe,
	input wire logic pumpEnable,
	input wire cfc_pkg::cfc_bridge_t bridgeA,
	input wire cfc_pkg::cfc_bridge_t bridgeB
);
	logic driveA;
	logic decA;
	logic [7:0] onCnt_q;
	// shoot-through or both high sides on would not be low-side slow decay
	function automatic logic badLeg(cfc_bridge_t b);
		return (b.hiA & (b.loA | b.hiB)) | (b.hiB & b.loB);
	endfunction
	assign driveA = bridgeA.hiA | bridgeA.hiB;
	assign decA = bridgeA.loA & bridgeA.loB;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			onCnt_q <= 8'h00;
		end else begin
			onCnt_q <= driveA ? onCnt_q + 8'h01 : 8'h00;
		end
	end
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	chk_fault_lock: assert property ((supplyLowLockout || pumpLowLockout || otherFault)[*3] |=> !faultFlagLowOe)
		else $error("fault pin not low");
	chk_supply_off: assert property (supplyLowLockout[*3] |=> bridgeA == BRIDGE_OFF && !pumpEnable)
		else $error("supply lockout not obeyed");
	chk_pump_kept: assert property ((pumpLowLockout && !supplyLowLockout)[*3] |=> bridgeB == BRIDGE_OFF && pumpEnable)
		else $error("pump lockout not obeyed");
	chk_fault_free: assert property ((!supplyLowLockout && !pumpLowLockout && !otherFault && !stallDetected)[*4]
		|=> faultFlagLowOe)
		else $error("fault pin held");
	chk_slow_only: assert property (!badLeg(bridgeA) && !badLeg(bridgeB))
		else $error("illegal bridge state");
	chk_min_on: assert property ($fell(driveA) && decA |-> onCnt_q >= BLANK_COUNT)
		else $error("drive phase too short");
	chk_trip_decay: assert property (tripLevel[0] && onCnt_q > BLANK_COUNT |-> ##[0:5] !driveA)
		else $error("trip ignored");
	chk_valley_end: assert property ($fell(decA) && driveA |-> $past(valleyLevel[0], 2))
		else $error("decay ended early");
endmodule
bind cfc_top cfc_chk #(.BLANK_COUNT(BLANK_COUNT)) i_chk (.core_clk, .rst_n, .supplyLowLockout, .pumpLowLockout,
	.otherFault, .stallDetected, .tripLevel, .valleyLevel, .faultFlagLowOe, .pumpEnable, .bridgeA, .bridgeB);

// ===== bench/test_cfc_top.sv
// bench for the chopper and fault control block
`timescale 1ns/10ps
module test_cfc_top;
	import cfc_pkg::*;
	logic core_clk = 1'b0, rst_n = 1'b0, supplyLowLockout = 1'b0, pumpLowLockout = 1'b0, otherFault = 1'b0;
	logic stallDetected = 1'b0, learnDone = 1'b0, extLow = 1'b0, stepIn = 1'b0, dirIn = 1'b0, lowPowerRequest = 1'b1;
	logic [1:0] microstepSelectLoRaw = 2'h0, stallModeSelectRaw = 2'h0, microstepSelectHiRaw = 2'h0, enableRaw = 2'h3;
	logic [1:0] tripLevel, valleyLevel;
	logic motorSupplyOk = 1'b1, faultFlagLowOut, stallReportOut;
	logic faultFlagLowOe, stallReportOe, pumpEnable, logicSupplyOut, stepOut, dirOut, stallReportSuppressed;
	logic stallReportIn;
	cfc_bridge_t bridgeA, bridgeB;
	cfc_cfg_t cfgOut;
	int fails = 0, num_checks = 0;
	// pull-up on the stall wire; host may hold it low
	assign stallReportIn = (stallReportOe ? 1'b1 : stallReportOut) && !extLow;
	cfc_top #(.BLANK_COUNT(4)) i_dut (.core_clk, .rst_n, .supplyLowLockout, .pumpLowLockout, .motorSupplyOk,
		.tripLevel, .valleyLevel, .windingPolarity(2'h1), .otherFault, .stallDetected, .learnDone, .stepIn, .dirIn,
		.lowPowerRequest, .microstepSelectLoRaw, .stallModeSelectRaw, .enableRaw, .microstepSelectHiRaw,
		.stallReportIn, .faultFlagLowOut, .faultFlagLowOe, .stallReportOut, .stallReportOe, .bridgeA, .bridgeB,
		.pumpEnable, .logicSupplyOut, .cfgOut, .stepOut, .dirOut, .stallReportSuppressed);
	cfc_winding_model i_motor (.core_clk, .bridgeA, .bridgeB, .tripLevel, .valleyLevel);
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(input logic seen, input logic exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		if (fails == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// bounded wait for slow decay on winding a
	task automatic wait_dec();
		int n;
		for (n = 0; n < 400 && !(bridgeA.loA && bridgeA.loB); n++) cyc(1);
		if (n == 400) begin
			fails++;
			finish_test();
		end
		chk(bridgeA.hiA | bridgeA.hiB, 1'b0);
	endtask
	initial begin
		cyc(16);
		rst_n = 1'b1;
		cyc(2);
		chk(faultFlagLowOe, 1'b1);
		wait_dec();
		supplyLowLockout = 1'b1;
		cyc(5);
		chk(faultFlagLowOe, 1'b0);
		chk(bridgeB === BRIDGE_OFF && !pumpEnable, 1'b1);
		pumpLowLockout = 1'b1;
		supplyLowLockout = 1'b0;
		cyc(5);
		chk(faultFlagLowOe, 1'b0);
		chk(bridgeA === BRIDGE_OFF && pumpEnable, 1'b1);
		otherFault = 1'b1;
		pumpLowLockout = 1'b0;
		cyc(5);
		chk(faultFlagLowOe, 1'b0);
		otherFault = 1'b0;
		cyc(5);
		chk(faultFlagLowOe, 1'b1);
		wait_dec(); // chopping resumes unaided
		chk(stallReportOe, 1'b0);
		chk(stallReportSuppressed, 1'b0);
		chk(faultFlagLowOut, 1'b0);
		chk(stallReportOut, 1'b0);
		stallDetected = 1'b1;
		cyc(10);
		chk(stallReportOe, 1'b1);
		chk(faultFlagLowOe, 1'b0);
		extLow = 1'b1;
		cyc(10);
		chk(stallReportSuppressed && faultFlagLowOe, 1'b1);
		stallDetected = 1'b0;
		extLow = 1'b0;
		stallModeSelectRaw = 2'h2;
		cyc(5);
		chk(stallReportOe, 1'b1);
		learnDone = 1'b1;
		cyc(5);
		chk(stallReportOe, 1'b0);
		for (int i = 0; i < 4; i++) begin
			cfc_tri_t expTri;
			expTri = (i == 3) ? CFC_LVL_HIGH : ((i == 0) ? CFC_LVL_LOW : CFC_LVL_FLOAT);
			microstepSelectLoRaw = 2'(i);
			stallModeSelectRaw = 2'(i);
			enableRaw = 2'(i);
			microstepSelectHiRaw = 2'(i);
			{dirIn, stepIn} = 2'(i);
			cyc(4);
			chk(cfgOut.microstepSelectLo === expTri, 1'b1);
			chk(cfgOut.stallModeSelect === expTri, 1'b1);
			chk(cfgOut.enableSel === expTri, 1'b1);
			chk(cfgOut.microstepSelectHi === 2'(i), 1'b1);
			chk({dirOut, stepOut} === 2'(i), 1'b1);
		end
		lowPowerRequest = 1'b0;
		cyc(5);
		chk(logicSupplyOut, 1'b0);
		lowPowerRequest = 1'b1; // driven, never tied to the logic supply
		motorSupplyOk = 1'b0;
		cyc(5);
		chk(logicSupplyOut, 1'b0);
		motorSupplyOk = 1'b1;
		cyc(5);
		chk(logicSupplyOut, 1'b1);
		finish_test();
	end
endmodule
